/* hvc_config_regs.v */
// Contract
// - Primary config is 8 bits, resets zero, reached only via data port.
// - Primary bit 7 set suppresses thermal shutdown of wake-up/aux driver.
// - Primary bit 6 powers 131 kHz precision oscillator up or down.
// - Primary bit 5 disables LIN pull-up, selects bit-serial pin mode.
// - Primary bit 4 drives wake-up pin high; clear releases to pull-down.
// - Primary bit 3 enables supply monitor; interrupt below 6 V if enabled.
// - Primary bit 2 enables low voltage flag, reported in monitor bit 3.
// - Primary bits 1:0 LIN mode: 00 off, 10 on, others reserved.
// - Secondary config is 8 bits, resets zero, via data port only.
// - Secondary bit 7 turns on attenuator diagnostic current source.
// - Commands 08/09 write primary/secondary; 00/01 read them back.
// - Commands cross a 2.56 MHz serial link, at most 10 us latency.
`timescale 1ns/1ps
`include "hvc_defines.vh"

module hvc_config_regs #(
	parameter FRAME_BITS = `HVC_FRAME_BITS
) (
	input  wire       clock,
	input  wire       reset_n,
	input  wire       cmd_wr,
	input  wire [7:0] cmd_wdata,
	input  wire       dat_wr,
	input  wire [7:0] dat_wdata,
	input  wire [7:0] mon_status,
	input  wire [7:0] aux_status,
	output reg  [7:0] cmd_rdata,
	output reg [11:0] dat_rdata,
	output reg        therm_shutdown_dis,
	output reg        osc_en,
	output reg        bit_serial_mode,
	output reg        lin_pullup_en,
	output reg        wakeup_pin_out,
	output reg        wakeup_pin_oe_n,
	output reg        supply_monitor_en,
	output reg        low_voltage_flag_en,
	output reg  [1:0] lin_mode,
	output reg        lin_drv_en,
	output reg        atten_diag_en
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_SEND = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [1:0] state_r;
	reg [7:0] cmd_r;
	reg [7:0] stage_r;
	reg [7:0] pri_r;
	reg [7:0] sec_r;
	reg [5:0] bit_r;
	reg       phase_r;
	reg       rd_ok_r;
	reg       wr_ok_r;
	wire      tick;

	function is_valid;
		input [7:0] c;
		begin
			is_valid = (c == `HVC_CMD_RD_PRI) || (c == `HVC_CMD_RD_SEC) ||
				(c == `HVC_CMD_RD_STA) || (c == `HVC_CMD_RD_MON) ||
				(c == `HVC_CMD_WR_PRI) || (c == `HVC_CMD_WR_SEC);
		end
	endfunction

	function is_write;
		input [7:0] c;
		begin
			is_write = (c == `HVC_CMD_WR_PRI) || (c == `HVC_CMD_WR_SEC);
		end
	endfunction

	function [7:0] read_source;
		input [1:0] sel;
		input [7:0] in_pri;
		input [7:0] in_sec;
		input [7:0] in_sta;
		input [7:0] in_mon;
		begin
			case (sel)
			2'h0:    read_source = in_pri;
			2'h1:    read_source = in_sec;
			2'h2:    read_source = in_sta;
			default: read_source = in_mon;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Serial link pacing
	// ----------------------------------------
	// Divider cleared outside frames so every frame starts aligned
	// one tick per link half-bit period
	hvc_link_div u_div (
		.clock   (clock),
		.reset_n (reset_n),
		.run     (state_r == ST_SEND),
		.tick    (tick)
	);

	// ----------------------------------------
	// Command engine
	// ----------------------------------------
	// Each frame takes 2*FRAME_BITS link half-periods, well inside 10 us.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			cmd_r   <= 8'h00;
			stage_r <= 8'h00;
			pri_r   <= `HVC_PRI_RESET;
			sec_r   <= `HVC_SEC_RESET;
			bit_r   <= 6'h00;
			phase_r <= 1'b0;
			rd_ok_r <= 1'b0;
			wr_ok_r <= 1'b0;
		end else begin
			// Staging only while idle so a frame in flight is not corrupted
			if (dat_wr && state_r == ST_IDLE) begin
				stage_r <= dat_wdata;
			end
			case (state_r)
			ST_IDLE: begin
				// commands while busy are dropped
				// Refused strobes leave no flag; software polls busy first
				if (cmd_wr) begin
					cmd_r   <= cmd_wdata;
					bit_r   <= 6'h00;
					phase_r <= 1'b0;
					state_r <= ST_SEND;
				end
			end
			ST_SEND: begin
				if (tick) begin
					phase_r <= ~phase_r;
					if (phase_r) begin
						if (bit_r == FRAME_BITS[5:0] - 6'h01) begin
							state_r <= ST_DONE;
						end else begin
							bit_r <= bit_r + 6'h01;
						end
					end
				end
			end
			ST_DONE: begin
				case (cmd_r)
				`HVC_CMD_WR_PRI: pri_r <= stage_r;
				`HVC_CMD_WR_SEC: sec_r <= stage_r;
				default: begin
					// Unknown codes leave registers and staging unchanged; both ok flags clear
					if (is_valid(cmd_r)) begin
						stage_r <= read_source(cmd_r[1:0], pri_r, sec_r, aux_status, mon_status);
					end
				end
				endcase
				wr_ok_r <= is_write(cmd_r);
				rd_ok_r <= is_valid(cmd_r) && !is_write(cmd_r);
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Command and data port readback
	// ----------------------------------------
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata <= 8'h00;
			dat_rdata <= 12'h000;
		end else begin
			// busy indication
			// Strobe folded in so a poll right after the command sees busy
			cmd_rdata <= {5'h00, wr_ok_r, rd_ok_r, (state_r != ST_IDLE) | cmd_wr};
			dat_rdata <= {cmd_r[3:0], stage_r};
		end
	end

	// ----------------------------------------
	// Pin controls
	// ----------------------------------------
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			therm_shutdown_dis  <= 1'b0;
			osc_en              <= 1'b0;
			bit_serial_mode     <= 1'b0;
			lin_pullup_en       <= 1'b1;
			wakeup_pin_out      <= 1'b0;
			wakeup_pin_oe_n     <= 1'b1;
			supply_monitor_en   <= 1'b0;
			low_voltage_flag_en <= 1'b0;
			lin_mode            <= `HVC_LIN_OFF;
			lin_drv_en          <= 1'b0;
			atten_diag_en       <= 1'b0;
		end else begin
			therm_shutdown_dis  <= pri_r[`HVC_PRI_THERM_DIS];
			osc_en              <= pri_r[`HVC_PRI_OSC_EN];
			bit_serial_mode     <= pri_r[`HVC_PRI_BSD_EN];
			lin_pullup_en       <= ~pri_r[`HVC_PRI_BSD_EN];
			wakeup_pin_out      <= pri_r[`HVC_PRI_WAKE_ASSERT];
			wakeup_pin_oe_n     <= ~pri_r[`HVC_PRI_WAKE_ASSERT];
			supply_monitor_en   <= pri_r[`HVC_PRI_PSM_EN];
			low_voltage_flag_en <= pri_r[`HVC_PRI_LVF_EN];
			// LIN mode, driver only on code 10
			// Reserved codes are kept as written, driver stays off
			lin_mode   <= pri_r[`HVC_PRI_LIN_HI:`HVC_PRI_LIN_LO];
			lin_drv_en <= (pri_r[`HVC_PRI_LIN_HI:`HVC_PRI_LIN_LO] == `HVC_LIN_ON);
			atten_diag_en <= sec_r[`HVC_SEC_ATTEN_DIAG];
		end
	end
endmodule // hvc_config_regs

/* hvc_config_regs_props.sv */
`timescale 1ns/1ps
module hvc_config_regs_props (
	input wire        clock,
	input wire        reset_n,
	input wire        cmd_wr,
	input wire        dat_wr,
	input wire [7:0]  cmd_rdata,
	input wire [11:0] dat_rdata,
	input wire        osc_en,
	input wire        atten_diag_en,
	input wire        bit_serial_mode,
	input wire        lin_pullup_en,
	input wire        wakeup_pin_out,
	input wire        wakeup_pin_oe_n,
	input wire [1:0]  lin_mode,
	input wire        lin_drv_en
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_pullup_vs_mode: assert property (lin_pullup_en == !bit_serial_mode)
		else $error("pull-up not inverse of bit-serial mode");
	a_wake_drive_pair: assert property (wakeup_pin_oe_n == !wakeup_pin_out)
		else $error("wake-up enable not inverse of level");
	a_lin_drv_code: assert property (lin_drv_en == (lin_mode == 2'h2))
		else $error("driver enable wrong for mode");
	a_busy_on_cmd: assert property (cmd_wr && !cmd_rdata[0] |=> cmd_rdata[0])
		else $error("busy did not rise after command");
	a_busy_bounded: assert property ($rose(cmd_rdata[0]) |-> ##[1:1000] !cmd_rdata[0])
		else $error("command not completed in time");
	a_cfg_only_done: assert property (
		($changed(osc_en) || $changed(atten_diag_en)) |-> !cmd_rdata[0])
		else $error("config output changed while busy");
	a_idle_data_hold: assert property (
		!cmd_rdata[0] && !cmd_wr && !dat_wr && !$past(dat_wr) |=> $stable(dat_rdata))
		else $error("data port changed while idle");
	a_reserved_zero: assert property (cmd_rdata[7:3] == 5'h00)
		else $error("reserved status bits set");
endmodule // hvc_config_regs_props

bind hvc_config_regs hvc_config_regs_props i_props (.clock, .reset_n, .cmd_wr, .dat_wr,
	.cmd_rdata, .dat_rdata, .osc_en, .atten_diag_en, .bit_serial_mode, .lin_pullup_en,
	.wakeup_pin_out, .wakeup_pin_oe_n, .lin_mode, .lin_drv_en);

/* hvc_config_regs_tb.sv */
`timescale 1ns/1ps
module hvc_config_regs_tb;
	reg         clock, reset_n, cmd_wr, dat_wr;
	reg  [7:0]  cmd_wdata, dat_wdata, mon_status, aux_status, v;
	wire [7:0]  cmd_rdata;
	wire [11:0] dat_rdata;
	wire        tsd, osc, bsm, pup, wko, woe, smon, lowv, drv, diag;
	wire [1:0]  mode;
	wire [7:0]  pri = {tsd, osc, bsm, wko, smon, lowv, mode};
	integer     miscompares, total_checks, cycles, i;

	// Short frame keeps the run brief
	hvc_config_regs #(.FRAME_BITS(2)) i_dut (.clock(clock), .reset_n(reset_n),
		.cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .dat_wr(dat_wr), .dat_wdata(dat_wdata),
		.mon_status(mon_status), .aux_status(aux_status), .cmd_rdata(cmd_rdata),
		.dat_rdata(dat_rdata), .therm_shutdown_dis(tsd), .osc_en(osc),
		.bit_serial_mode(bsm), .lin_pullup_en(pup), .wakeup_pin_out(wko),
		.wakeup_pin_oe_n(woe), .supply_monitor_en(smon), .low_voltage_flag_en(lowv),
		.lin_mode(mode), .lin_drv_en(drv), .atten_diag_en(diag));

	task end_sim;
		begin
			if (miscompares == 0 && total_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [11:0] got, input [11:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("BAD %0t got %0h exp %0h", $time, got, exp);
			end
		end
	endtask
	task wait_idle;
		integer n;
		begin
			n = 0;
			while (cmd_rdata[0] !== 1'b0 && n < 2000) begin
				@(negedge clock);
				n = n + 1;
			end
			if (n >= 2000) begin
				miscompares = miscompares + 1;
				$display("BAD %0t busy %0h exp %0h", $time, cmd_rdata, 8'h00);
			end
			@(negedge clock);
		end
	endtask
	task send(input [7:0] c);
		begin
			@(negedge clock);
			cmd_wr = 1'b1;
			cmd_wdata = c;
			@(negedge clock);
			cmd_wr = 1'b0;
			wait_idle;
		end
	endtask
	task wr(input [7:0] c, input [7:0] d);
		begin
			@(negedge clock);
			dat_wr = 1'b1;
			dat_wdata = d;
			@(negedge clock);
			dat_wr = 1'b0;
			send(c);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		begin
			chk(pri, 12'h000);
			chk({pup, woe, drv, diag}, 12'h00C);
			send(8'h00);
			chk(dat_rdata, 12'h000);
			send(8'h01);
			chk(dat_rdata, 12'h100);
		end
	endtask
	task t_primary;
		begin
			for (i = 0; i < 10; i = i + 1) begin
				v = (i == 0) ? 8'h7E : (i == 8) ? 8'hFE : (i == 9) ? 8'h00 : 8'h01 << i;
				wr(8'h08, v);
				chk(pri, {4'h0, v});
				chk({pup, woe, drv}, {~v[5], ~v[4], v[1:0] == 2'h2});
				chk(cmd_rdata[2:0], 12'h004);
				send(8'h00);
				chk(dat_rdata, {4'h0, v});
				chk(cmd_rdata[2:0], 12'h002);
			end
		end
	endtask
	task t_secondary;
		begin
			wr(8'h09, 8'h80);
			chk({diag, pri}, 12'h100);
			send(8'h01);
			chk(dat_rdata, 12'h180);
			wr(8'h09, 8'h00);
			chk(diag, 12'h000);
		end
	endtask
	task t_refuse;
		begin
			wr(8'h08, 8'hA2);
			@(negedge clock);
			cmd_wr = 1'b1;
			cmd_wdata = 8'h00;
			@(negedge clock);
			dat_wr = 1'b1;
			dat_wdata = 8'hFE;
			cmd_wdata = 8'h08;
			@(negedge clock);
			dat_wr = 1'b0;
			cmd_wr = 1'b0;
			wait_idle;
			chk({drv, pri}, 12'h1A2);
			chk(dat_rdata, 12'h0A2);
			send(8'h05);
			chk({cmd_rdata[2:1], pri}, 12'h0A2);
			send(8'h03);
			chk(dat_rdata, 12'h35A);
			send(8'h02);
			chk(dat_rdata, 12'h2C3);
		end
	endtask
	task t_midreset;
		begin
			wr(8'h09, 8'h80);
			@(negedge clock);
			reset_n = 1'b0;
			@(negedge clock);
			chk({pup, woe, diag, pri}, 12'h600);
			reset_n = 1'b1;
			send(8'h01);
			chk(dat_rdata, 12'h100);
		end
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 50000) begin
			miscompares = miscompares + 1;
			end_sim;
		end
	end
	initial begin
		{reset_n, cmd_wr, dat_wr, cmd_wdata, dat_wdata} = 0;
		mon_status = 8'h5A;
		aux_status = 8'hC3;
		miscompares = 0;
		total_checks = 0;
		cycles = 0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		t_reset;
		t_primary;
		t_secondary;
		t_refuse;
		t_midreset;
		end_sim;
	end
endmodule // hvc_config_regs_tb

/* hvc_defines.vh */
`ifndef HVC_DEFINES_VH
`define HVC_DEFINES_VH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define HVC_CMD_RD_PRI      8'h00
`define HVC_CMD_RD_SEC      8'h01
`define HVC_CMD_RD_STA      8'h02
`define HVC_CMD_RD_MON      8'h03
`define HVC_CMD_WR_PRI      8'h08
`define HVC_CMD_WR_SEC      8'h09

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HVC_PRI_RESET       8'h00
`define HVC_SEC_RESET       8'h00

// ----------------------------------------
// Primary register fields
// ----------------------------------------
`define HVC_PRI_THERM_DIS   7
`define HVC_PRI_OSC_EN      6
`define HVC_PRI_BSD_EN      5
`define HVC_PRI_WAKE_ASSERT 4
`define HVC_PRI_PSM_EN      3
`define HVC_PRI_LVF_EN      2
`define HVC_PRI_LIN_HI      1
`define HVC_PRI_LIN_LO      0
`define HVC_LIN_OFF         2'h0
`define HVC_LIN_ON          2'h2

// ----------------------------------------
// Secondary register fields
// ----------------------------------------
`define HVC_SEC_ATTEN_DIAG  7

// ----------------------------------------
// Command port status bits
// ----------------------------------------
`define HVC_STAT_BUSY       0
`define HVC_STAT_RD_OK      1
`define HVC_STAT_WR_OK      2

// ----------------------------------------
// Link timing
// ----------------------------------------
`define HVC_CLK_HZ          100000000
`define HVC_LINK_HZ         2560000
// Half period of serial clock, rounded up
`define HVC_LINK_HALF       ((`HVC_CLK_HZ + 2*`HVC_LINK_HZ - 1) / (2*`HVC_LINK_HZ))
// Frame: 8 command bits + 8 data bits each way
`define HVC_FRAME_BITS      16
`define HVC_LATENCY_US      10
`define HVC_LATENCY_CYC     ((`HVC_CLK_HZ / 1000000) * `HVC_LATENCY_US)

`endif

/* hvc_link_div.v */
`timescale 1ns/1ps
`include "hvc_defines.vh"

// Serial link half-bit-period enable divider.
module hvc_link_div #(
	parameter HALF = `HVC_LINK_HALF
) (
	input  wire clock,
	input  wire reset_n,
	input  wire run,
	output reg  tick
);
	reg [7:0] cnt_r;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_r <= 8'h00;
			tick  <= 1'b0;
		end else if (cnt_r == HALF[7:0] - 8'h01) begin
			cnt_r <= 8'h00;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			tick  <= 1'b0;
		end
	end
endmodule // hvc_link_div
